// ==== ptid_consts.svh ====
// offsets, field positions, reset values and codes of the target decoder
`ifndef PTID_CONSTS_SVH
`define PTID_CONSTS_SVH

// register byte offsets
`define PTID_OFS_W0_CTL      8'h00
`define PTID_OFS_W0_ADD      8'h04
`define PTID_OFS_W1_CTL      8'h08
`define PTID_OFS_W1_ADD      8'h0C
`define PTID_OFS_MISC        8'h10
`define PTID_OFS_MISC2       8'h14
`define PTID_OFS_STAT        8'h18

// window control word fields
`define PTID_CTL_EN          31
`define PTID_CTL_POST        30
`define PTID_CTL_PREF        29
`define PTID_CTL_BWR         28
`define PTID_CTL_FLIP        27
`define PTID_CTL_SPACE       26
`define PTID_CTL_DSZ_HI      25
`define PTID_CTL_DSZ_LO      24
`define PTID_CTL_XC_HI       11
`define PTID_CTL_XC_LO       8
`define PTID_CTL_SZ_HI       3
`define PTID_CTL_SZ_LO       0
`define PTID_CTL_WMASK       32'hFF00_0F0F

// window address word: base on top, translation base below
`define PTID_ADD_BASE_HI     31
`define PTID_ADD_BASE_LO     16
`define PTID_ADD_WMASK       32'hFFFF_FFFF

// global settings
`define PTID_MISC_ORDER      31
`define PTID_MISC_WMASK      32'h8000_003F
`define PTID_MISC2_PERWIN    31
`define PTID_MISC2_BURST4    30
`define PTID_MISC2_SINGLE    29
`define PTID_MISC2_BUSY      28
`define PTID_MISC2_WMASK     32'hF000_003F
`define PTID_CNT_HI          5
`define PTID_CNT_LO          0

// status word fields
`define PTID_STAT_ACTIVE     0
`define PTID_STAT_WIN        1
`define PTID_STAT_CFG        2
`define PTID_STAT_DEVT_HI    5
`define PTID_STAT_DEVT_LO    4
`define PTID_STAT_CNT_HI     31
`define PTID_STAT_CNT_LO     16
`define PTID_DEVSEL_MEDIUM   2'h1

// reset values
`define PTID_RST_WORD        32'h0000_0000

// bus command codes
`define PTID_CMD_IO_RD       4'h2
`define PTID_CMD_IO_WR       4'h3
`define PTID_CMD_MEM_RD      4'h6
`define PTID_CMD_MEM_WR      4'h7
`define PTID_CMD_CFG_RD      4'hA
`define PTID_CMD_CFG_WR      4'hB
`define PTID_CMD_MEM_RDM     4'hC
`define PTID_CMD_MEM_RDL     4'hE
`define PTID_CMD_MEM_WRI     4'hF

// axi responses
`define PTID_RESP_OKAY       2'h0
`define PTID_RESP_SLVERR     2'h2

`endif

// ==== ptid_pkg.sv ====
// types shared by the target decoder
package ptid_pkg;

    typedef struct packed {
        logic        en;
        logic        post;
        logic        pref;
        logic        bwr;
        logic        flip;
        logic        space;
        logic [1:0]  dsz;
        logic [3:0]  xc;
        logic [3:0]  szc;
        logic [15:0] base;
        logic [15:0] trans;
    } ptid_win_t;

    typedef struct packed {
        logic        win;
        logic        rd;
        logic        io;
        logic [3:0]  be_n;
        logic [31:0] addr;
        logic [15:0] translation_base;
        logic [3:0]  xact_code;
        logic [1:0]  dest_port_width;
        logic        post_write_on;
        logic        prefetch_on;
        logic [5:0]  prefetch_amount;
        logic        burst_write_on;
        logic        byte_order;
        logic        burst_four;
        logic        single_beat_prefetch;
        logic        hold_bus_busy;
    } ptid_cyc_t;

endpackage

// ==== ptid_decoder.sv ====
// target window decoder with axi4-lite register slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ptid_consts.svh"

// Operation
// - claim only on enabled window address match or type 0 config access
// - two independent windows, identical capability except that only window 1 can use the second count
// - disabled windows never claim
// - space bit picks memory or io
// - size code doubles from 64 kbytes
// - compare only size-significant top bits
// - devsel two clocks after frame, medium
// - answer io, memory, type 0 config
// - read/write aliases act as plain memory
// - cycle type from window, command, enables
// - posting bit per window
// - transaction code per window
// - port width per window
// - prefetch bit per window, shared count
// - per-window bit selects second count for window 1 prefetch
// - burst write bit per window
// - flip inverts global byte order
// - global four-beat burst bit
// - global single-beat prefetch bit
// - global keep-busy bit
module ptid_decoder #(
    parameter int WIN_NUM = 2
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // axi4-lite write
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pci address phase
    input  wire logic              pci_frame_n,
    input  wire logic              pci_irdy_n,
    input  wire logic              pci_idsel,
    input  wire logic [31:0]       pci_ad,
    input  wire logic [3:0]        pci_cbe_n,
    // pci device select pin
    output logic                   pci_devsel_n_o,
    output logic                   pci_devsel_oe_n,
    // local-bus cycle setup
    output ptid_pkg::ptid_cyc_t    cyc,
    output logic                   cyc_valid,
    output logic                   cfg_claim,
    output logic                   target_on
);

    if (WIN_NUM != 2) begin : g_bad_win_num
        $error("ptid_decoder serves exactly two windows");
    end

    localparam logic [2:0] IDX_NONE = 3'h7;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `PTID_OFS_W0_CTL: reg_index = 3'h0;
            `PTID_OFS_W0_ADD: reg_index = 3'h1;
            `PTID_OFS_W1_CTL: reg_index = 3'h2;
            `PTID_OFS_W1_ADD: reg_index = 3'h3;
            `PTID_OFS_MISC:   reg_index = 3'h4;
            `PTID_OFS_MISC2:  reg_index = 3'h5;
            `PTID_OFS_STAT:   reg_index = 3'h6;
            default:          reg_index = IDX_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st,
                                          input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic ptid_pkg::ptid_win_t win_of(input logic [31:0] c,
                                                  input logic [31:0] a);
        ptid_pkg::ptid_win_t w;
        w.en    = c[`PTID_CTL_EN];
        w.post  = c[`PTID_CTL_POST];
        w.pref  = c[`PTID_CTL_PREF];
        w.bwr   = c[`PTID_CTL_BWR];
        w.flip  = c[`PTID_CTL_FLIP];
        w.space = c[`PTID_CTL_SPACE];
        w.dsz   = c[`PTID_CTL_DSZ_HI:`PTID_CTL_DSZ_LO];
        w.xc    = c[`PTID_CTL_XC_HI:`PTID_CTL_XC_LO];
        w.szc   = c[`PTID_CTL_SZ_HI:`PTID_CTL_SZ_LO];
        w.base  = a[`PTID_ADD_BASE_HI:`PTID_ADD_BASE_LO];
        w.trans = a[15:0];
        win_of  = w;
    endfunction

    // size code n leaves the top 16-n address bits significant
    function automatic logic win_hit(input ptid_pkg::ptid_win_t w,
                                     input logic [31:0] ad,
                                     input logic        io);
        logic [15:0] m;
        m = 16'hFFFF << w.szc;
        win_hit = w.en && (w.space == io)
                  && (((ad[31:16] ^ w.base) & m) == 16'h0000);
    endfunction

    // register file
    logic [31:0]         ctl_r  [WIN_NUM];
    logic [31:0]         ctl_nxt[WIN_NUM];
    logic [31:0]         add_r  [WIN_NUM];
    logic [31:0]         add_nxt[WIN_NUM];
    logic [31:0]         misc_r, misc_nxt, misc2_r, misc2_nxt;
    ptid_pkg::ptid_win_t win    [WIN_NUM];
    logic [WIN_NUM-1:0]  hit;

    // axi write state
    logic       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] wa_r, wa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic       awready_nxt, wready_nxt, bvalid_nxt;
    logic [1:0] bresp_nxt;
    logic       do_wr;
    logic [2:0] widx;

    // axi read state
    logic       arready_nxt, rvalid_nxt;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_nxt;
    logic [2:0] ridx;

    // pci state
    logic       frame_q_r, stage_r, stage_nxt, claim_r, claim_nxt;
    logic       st_win_r, st_win_nxt, st_cfg_r, st_cfg_nxt;
    logic       st_rd_r, st_rd_nxt, st_io_r, st_io_nxt;
    logic [31:0] st_ad_r, st_ad_nxt;
    logic       devsel_nxt, oe_nxt, cyc_valid_nxt, cfg_claim_nxt;
    logic       target_on_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    ptid_pkg::ptid_cyc_t cyc_nxt;
    logic       addr_ph, cmd_io, cmd_mem, cmd_rd, cmd_cfg, cfg_hit;
    logic [3:0] cmd;

    for (genvar g = 0; g < WIN_NUM; g++) begin : g_win
        assign win[g] = win_of(ctl_r[g], add_r[g]);
        assign hit[g] = addr_ph && (cmd_io || cmd_mem)
                        && win_hit(win[g], pci_ad, cmd_io);
    end

    // axi write channel and register updates
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        wa_nxt      = wa_r;
        wd_nxt      = wd_r;
        ws_nxt      = ws_r;
        bvalid_nxt  = s_axi_bvalid;
        bresp_nxt   = s_axi_bresp;
        ctl_nxt     = ctl_r;
        add_nxt     = add_r;
        misc_nxt    = misc_r;
        misc2_nxt   = misc2_r;
        do_wr       = aw_have_r && w_have_r && !s_axi_bvalid;
        widx        = reg_index(wa_r);
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            wa_nxt      = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            wd_nxt     = s_axi_wdata;
            ws_nxt     = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = `PTID_RESP_OKAY;
            case (widx)
                3'h0: ctl_nxt[0] = merge(ctl_r[0], wd_r, ws_r,
                                         `PTID_CTL_WMASK);
                3'h1: add_nxt[0] = merge(add_r[0], wd_r, ws_r,
                                         `PTID_ADD_WMASK);
                3'h2: ctl_nxt[1] = merge(ctl_r[1], wd_r, ws_r,
                                         `PTID_CTL_WMASK);
                3'h3: add_nxt[1] = merge(add_r[1], wd_r, ws_r,
                                         `PTID_ADD_WMASK);
                3'h4: misc_nxt   = merge(misc_r, wd_r, ws_r,
                                         `PTID_MISC_WMASK);
                3'h5: misc2_nxt  = merge(misc2_r, wd_r, ws_r,
                                         `PTID_MISC2_WMASK);
                3'h6: ;
                default: bresp_nxt = `PTID_RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt  = !w_have_nxt && !bvalid_nxt;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            wa_r          <= 8'h00;
            wd_r          <= `PTID_RST_WORD;
            ws_r          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PTID_RESP_OKAY;
            ctl_r         <= '{default: `PTID_RST_WORD};
            add_r         <= '{default: `PTID_RST_WORD};
            misc_r        <= `PTID_RST_WORD;
            misc2_r       <= `PTID_RST_WORD;
        end else begin
            aw_have_r     <= aw_have_nxt;
            w_have_r      <= w_have_nxt;
            wa_r          <= wa_nxt;
            wd_r          <= wd_nxt;
            ws_r          <= ws_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready  <= wready_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            ctl_r         <= ctl_nxt;
            add_r         <= add_nxt;
            misc_r        <= misc_nxt;
            misc2_r       <= misc2_nxt;
        end
    end

    // axi read channel
    always_comb begin
        rvalid_nxt = s_axi_rvalid;
        rresp_nxt  = s_axi_rresp;
        rdata_nxt  = s_axi_rdata;
        ridx       = reg_index(s_axi_araddr);
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `PTID_RESP_OKAY;
            rdata_nxt  = `PTID_RST_WORD;
            case (ridx)
                3'h0: rdata_nxt = ctl_r[0];
                3'h1: rdata_nxt = add_r[0];
                3'h2: rdata_nxt = ctl_r[1];
                3'h3: rdata_nxt = add_r[1];
                3'h4: rdata_nxt = misc_r;
                3'h5: rdata_nxt = misc2_r;
                3'h6: begin
                    rdata_nxt[`PTID_STAT_ACTIVE] = claim_r;
                    rdata_nxt[`PTID_STAT_WIN]    = st_win_r;
                    rdata_nxt[`PTID_STAT_CFG]    = st_cfg_r;
                    rdata_nxt[`PTID_STAT_DEVT_HI:`PTID_STAT_DEVT_LO] =
                        `PTID_DEVSEL_MEDIUM;
                    rdata_nxt[`PTID_STAT_CNT_HI:`PTID_STAT_CNT_LO] = cnt_r;
                end
                default: rresp_nxt = `PTID_RESP_SLVERR;
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `PTID_RESP_OKAY;
            s_axi_rdata   <= `PTID_RST_WORD;
        end else begin
            s_axi_arready <= arready_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rresp   <= rresp_nxt;
            s_axi_rdata   <= rdata_nxt;
        end
    end

    // pci decode: address edge, one stage, then devsel
    always_comb begin
        cmd     = pci_cbe_n;
        addr_ph = !pci_frame_n && frame_q_r && !claim_r && !stage_r;
        cmd_io  = (cmd == `PTID_CMD_IO_RD) || (cmd == `PTID_CMD_IO_WR);
        cmd_mem = (cmd == `PTID_CMD_MEM_RD) || (cmd == `PTID_CMD_MEM_WR)
                  || (cmd == `PTID_CMD_MEM_RDM) || (cmd == `PTID_CMD_MEM_RDL)
                  || (cmd == `PTID_CMD_MEM_WRI);
        cmd_rd  = (cmd == `PTID_CMD_IO_RD) || (cmd == `PTID_CMD_MEM_RD)
                  || (cmd == `PTID_CMD_MEM_RDM) || (cmd == `PTID_CMD_MEM_RDL)
                  || (cmd == `PTID_CMD_CFG_RD);
        cmd_cfg = (cmd == `PTID_CMD_CFG_RD) || (cmd == `PTID_CMD_CFG_WR);
        cfg_hit = addr_ph && cmd_cfg && pci_idsel
                  && (pci_ad[1:0] == 2'b00);
        stage_nxt  = addr_ph && ((|hit) || cfg_hit);
        st_win_nxt = st_win_r;
        st_cfg_nxt = st_cfg_r;
        st_rd_nxt  = st_rd_r;
        st_io_nxt  = st_io_r;
        st_ad_nxt  = st_ad_r;
        if (stage_nxt) begin
            st_win_nxt = hit[1];
            st_cfg_nxt = !(|hit);
            st_rd_nxt  = cmd_rd;
            st_io_nxt  = cmd_io;
            st_ad_nxt  = pci_ad;
        end
        claim_nxt      = claim_r;
        devsel_nxt     = pci_devsel_n_o;
        oe_nxt         = pci_devsel_oe_n;
        cyc_valid_nxt  = 1'b0;
        cfg_claim_nxt  = 1'b0;
        cnt_nxt        = cnt_r;
        cyc_nxt        = cyc;
        if (stage_r) begin
            claim_nxt  = 1'b1;
            devsel_nxt = 1'b0;
            oe_nxt     = 1'b0;
            cnt_nxt    = cnt_r + 16'h0001;
            cfg_claim_nxt = st_cfg_r;
            cyc_valid_nxt = !st_cfg_r;
            if (!st_cfg_r) begin
                cyc_nxt.win  = st_win_r;
                cyc_nxt.rd   = st_rd_r;
                cyc_nxt.io   = st_io_r;
                // first data phase carries the byte enables
                cyc_nxt.be_n = pci_cbe_n;
                cyc_nxt.addr = st_ad_r;
                cyc_nxt.translation_base = win[st_win_r].trans;
                cyc_nxt.xact_code = win[st_win_r].xc;
                cyc_nxt.dest_port_width = win[st_win_r].dsz;
                cyc_nxt.post_write_on = win[st_win_r].post;
                cyc_nxt.prefetch_on = win[st_win_r].pref;
                cyc_nxt.prefetch_amount =
                    (st_win_r && misc2_r[`PTID_MISC2_PERWIN])
                    ? misc2_r[`PTID_CNT_HI:`PTID_CNT_LO]
                    : misc_r[`PTID_CNT_HI:`PTID_CNT_LO];
                cyc_nxt.burst_write_on = win[st_win_r].bwr;
                cyc_nxt.byte_order = misc_r[`PTID_MISC_ORDER]
                                     ^ win[st_win_r].flip;
                cyc_nxt.burst_four =
                    misc2_r[`PTID_MISC2_BURST4];
                cyc_nxt.single_beat_prefetch =
                    misc2_r[`PTID_MISC2_SINGLE];
                cyc_nxt.hold_bus_busy =
                    misc2_r[`PTID_MISC2_BUSY];
            end
        end else if (claim_r && pci_frame_n && !pci_irdy_n) begin
            claim_nxt  = 1'b0;
            devsel_nxt = 1'b1;
            oe_nxt     = 1'b1;
        end
        target_on_nxt = win[0].en || win[1].en;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frame_q_r       <= 1'b1;
            stage_r         <= 1'b0;
            claim_r         <= 1'b0;
            st_win_r        <= 1'b0;
            st_cfg_r        <= 1'b0;
            st_rd_r         <= 1'b0;
            st_io_r         <= 1'b0;
            st_ad_r         <= `PTID_RST_WORD;
            pci_devsel_n_o  <= 1'b1;
            pci_devsel_oe_n <= 1'b1;
            cyc_valid       <= 1'b0;
            cfg_claim       <= 1'b0;
            target_on       <= 1'b0;
            cnt_r           <= 16'h0000;
            cyc             <= '0;
        end else begin
            frame_q_r       <= pci_frame_n;
            stage_r         <= stage_nxt;
            claim_r         <= claim_nxt;
            st_win_r        <= st_win_nxt;
            st_cfg_r        <= st_cfg_nxt;
            st_rd_r         <= st_rd_nxt;
            st_io_r         <= st_io_nxt;
            st_ad_r         <= st_ad_nxt;
            pci_devsel_n_o  <= devsel_nxt;
            pci_devsel_oe_n <= oe_nxt;
            cyc_valid       <= cyc_valid_nxt;
            cfg_claim       <= cfg_claim_nxt;
            target_on       <= target_on_nxt;
            cnt_r           <= cnt_nxt;
            cyc             <= cyc_nxt;
        end
    end

    // checks
    sequence s_win_addr;
        addr_ph && (|hit);
    endsequence

    sequence s_miss_addr;
        addr_ph && !(|hit) && !cfg_hit;
    endsequence

    AST_DEVSEL_TWO_CLOCKS: assert property (@(posedge clock)
        disable iff (!nrst) s_win_addr |=> ##1 !pci_devsel_n_o)
        else $error("devsel late after window hit");

    AST_MISS_NO_DEVSEL: assert property (@(posedge clock)
        disable iff (!nrst) s_miss_addr |=> ##1 pci_devsel_n_o)
        else $error("devsel on missed address");

    AST_DISABLED_QUIET: assert property (@(posedge clock)
        disable iff (!nrst)
        (!win[0].en && !win[1].en) |-> (hit == '0))
        else $error("disabled window hit");

    AST_SPACE_MATCH: assert property (@(posedge clock)
        disable iff (!nrst)
        hit[0] |-> (win[0].space == cmd_io))
        else $error("window hit in wrong space");

    AST_XACT_CODE: assert property (@(posedge clock)
        disable iff (!nrst)
        (stage_r && !st_cfg_r) |=> (cyc.xact_code == $past(win[st_win_r].xc))
            && cyc_valid)
        else $error("transaction code not from window");

    AST_PREFETCH_SELECT: assert property (@(posedge clock)
        disable iff (!nrst)
        (stage_r && !st_cfg_r && st_win_r && misc2_r[`PTID_MISC2_PERWIN])
        |=> (cyc.prefetch_amount == $past(misc2_r[5:0])))
        else $error("second prefetch count not used");

    AST_BYTE_ORDER: assert property (@(posedge clock)
        disable iff (!nrst)
        cyc_valid |-> (cyc.byte_order
            == ($past(misc_r[`PTID_MISC_ORDER]) ^ $past(win[st_win_r].flip))))
        else $error("byte order not flipped per window");

    AST_READ_ALIAS: assert property (@(posedge clock)
        disable iff (!nrst)
        (s_win_addr and (cmd == `PTID_CMD_MEM_RDM)) |=> ##1 (cyc.rd && !cyc.io))
        else $error("read multiple not seen as read");

    AST_DEVSEL_HOLD: assert property (@(posedge clock)
        disable iff (!nrst)
        (claim_r && !(pci_frame_n && !pci_irdy_n)) |=> !pci_devsel_n_o)
        else $error("devsel dropped mid transaction");

endmodule // ptid_decoder

// ==== ptid_pcim.sv ====
// pci bus master model issuing target address phases
`timescale 1ns/1ps
module ptid_pcim (
    // clock
    input  wire logic        clock,
    // request from bench
    input  wire logic        go,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  cmd,
    input  wire logic        sel,
    // pci lines
    output logic             frame_n,
    output logic             irdy_n,
    output logic             idsel,
    output logic [31:0]      ad,
    output logic [3:0]       cbe_n
);
    int n = 0;
    initial begin
        frame_n = 1;
        irdy_n = 1;
        idsel = 0;
        ad = 0;
        cbe_n = 0;
    end
    // address only in its phase, then a changing pattern
    always @(posedge clock) begin
        ad <= go ? addr : ~ad;
        idsel <= go & sel;
        if (go) begin
            n <= 1;
            frame_n <= 0;
            cbe_n <= cmd;
        end else if (n > 0) begin
            n <= (n == 4) ? 0 : n + 1;
            // data phases: all byte lanes enabled
            cbe_n <= 4'h0;
            frame_n <= (n >= 3);
            irdy_n <= (n >= 4);
        end
    end
endmodule // ptid_pcim

// ==== pci_target_image_decoder_tb_top.sv ====
// self-checking bench of the target window decoder
`timescale 1ns/1ps
module pci_target_image_decoder_tb_top;
    logic        clock = 0, nrst = 0, go = 0, sel = 0;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0]  aa = 0, ra = 0;
    logic [31:0] wd = 0, pa = 0, rd, ad;
    logic [3:0]  pc = 0, cbe_n;
    logic [1:0]  br, rr;
    logic        awr, wrd, bv, arr, rv, fr_n, ir_n, ids, dv_n, oe_n;
    logic        cv, cc, ton;
    ptid_pkg::ptid_cyc_t cyc;
    int          err_count = 0, cmp_count = 0;
    always #10 clock = ~clock;
    ptid_pcim ptid_pcim_i (.clock(clock), .go(go), .addr(pa), .cmd(pc),
        .sel(sel), .frame_n(fr_n), .irdy_n(ir_n), .idsel(ids), .ad(ad),
        .cbe_n(cbe_n));
    ptid_decoder ptid_decoder_i (.clock(clock), .nrst(nrst),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .pci_frame_n(fr_n),
        .pci_irdy_n(ir_n), .pci_idsel(ids), .pci_ad(ad), .pci_cbe_n(cbe_n),
        .pci_devsel_n_o(dv_n), .pci_devsel_oe_n(oe_n), .cyc(cyc),
        .cyc_valid(cv), .cfg_claim(cc), .target_on(ton));
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic hang();
        err_count++;
        end_of_test();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        @(posedge clock);
        aa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (awv && awr) awv <= 0;
            if (wv && wrd) wv <= 0;
            if (bv) begin
                bry <= 0;
                chk("bresp", {30'h0, r}, {30'h0, br});
                return;
            end
        end
        hang();
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] r);
        @(posedge clock);
        ra <= a; arv <= 1; rry <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (arv && arr) arv <= 0;
            if (rv) begin
                rry <= 0;
                chk("rdata", e, rd);
                chk("rresp", {30'h0, r}, {30'h0, rr});
                return;
            end
        end
        hang();
    endtask
    // address phase, devsel judged two clocks after frame
    task automatic pci(input logic [31:0] a, input logic [3:0] c,
                       input logic s, e);
        @(posedge clock);
        pa <= a; pc <= c; sel <= s; go <= 1;
        @(posedge clock);
        go <= 0;
        repeat (2) @(posedge clock);
        #1 chk("claim", {29'h0, !e, !e, e}, {29'h0, dv_n, oe_n, cv | cc});
        repeat (4) @(posedge clock);
    endtask
    task automatic s_regs();
        axr(8'h00, 32'h0000_0000, 2'h0);
        chk("target_on", 32'h0, {31'h0, ton});
        axw(8'h00, 32'hFFFF_FFFF, 2'h0);
        axr(8'h00, 32'hFF00_0F0F, 2'h0);
        chk("target_on", 32'h1, {31'h0, ton});
        axw(8'h1C, 32'h0000_0001, 2'h2);
        axr(8'h1C, 32'h0000_0000, 2'h2);
        axr(8'h18, 32'h0000_0010, 2'h0);
    endtask
    task automatic s_hit();
        logic [3:0] cm [5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
        axw(8'h04, 32'h1234_0000, 2'h0);
        axw(8'h00, 32'hD000_0501, 2'h0);
        foreach (cm[i]) pci(32'h1235_0000, cm[i], 1'b0, 1'b1);
        chk("win0", 32'h0000_0035, {26'h0,
            cyc.burst_write_on, cyc.post_write_on, cyc.xact_code});
        pci(32'h1236_0000, 4'h6, 1'b0, 1'b0);
        pci(32'h1235_0000, 4'h2, 1'b0, 1'b0);
        pci(32'h0000_0000, 4'hA, 1'b1, 1'b1);
    endtask
    task automatic s_win1();
        axw(8'h10, 32'h8000_0011, 2'h0);
        axw(8'h14, 32'hF000_0022, 2'h0);
        axw(8'h0C, 32'h00AB_00CD, 2'h0);
        axw(8'h08, 32'hAD00_0A00, 2'h0);
        pci(32'h00AB_0004, 4'h3, 1'b0, 1'b1);
        chk("win1", 32'h0000_7A2A, {17'h0, cyc.burst_four,
            cyc.single_beat_prefetch, cyc.hold_bus_busy, cyc.win,
            cyc.byte_order, cyc.prefetch_amount, cyc.xact_code});
        chk("win1b", 32'h00CD_0302, {
            cyc.translation_base, 5'h0, cyc.dest_port_width,
            cyc.prefetch_on, cyc.burst_write_on, cyc.post_write_on,
            cyc.be_n, cyc.io, cyc.rd});
        chk("addr", 32'h00AB_0004, cyc.addr);
        axw(8'h08, 32'h2C00_0A00, 2'h0);
        pci(32'h00AB_0004, 4'h3, 1'b0, 1'b0);
        axw(8'h00, 32'h0000_0000, 2'h0);
        pci(32'h1235_0000, 4'h6, 1'b0, 1'b0);
        chk("target_on", 32'h0, {31'h0, ton});
        pci(32'h0000_0000, 4'hB, 1'b1, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1;
        s_regs();
        s_hit();
        s_win1();
        end_of_test();
    end
endmodule // pci_target_image_decoder_tb_top
